//--- src/ifc_mode_control.sv
// interface-mode control register of the transceiver and its pin effects
// What the document requires
// [RQ1] link sets at most one alternative interface field at a time
// [RQ2] reads at 07h-09h return register; write 07h, set 08h, clear 09h
// [RQ3] protection on: weak stop pull-up; stop high unexpectedly pulls data low
// [RQ4] protection on: detect when link stops driving the stop line
// [RQ5] protect-disable set: protection off, both weak resistors removed
// [RQ6] link always writes one to the unqualified-indicator bit
// [RQ7] fault complement output never qualified by bus-voltage comparator
// [RQ8] invert bit one inverts fault input; zero passes it straight
// [RQ9] clock-keep bit controls only internal clock power in serial modes
// [RQ10] clock-keep bit honoured only in serial modes with low-power bit one
// [RQ11] three-wire bit selects 3-bit serial interface, else parallel
// [RQ12] device clears three-wire bit when leaving three-wire mode
// [RQ13] six-wire bit selects 6-bit serial interface, else parallel
// [RQ14] device clears six-wire bit when leaving six-wire mode
// [RQ15] low-power bit active low; device sets it again on wake by stop
// [RQ16] set ORs written ones in, clear zeroes written ones, rest kept
`timescale 1ns/1ps
`default_nettype none
`include "ifc_defines.svh"
module ifc_mode_control
    import ifc_pkg::*;
#(
    parameter logic [3:0] STOP_HIGH_CYCLES = `IFC_STOP_HIGH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic phy_low_power_n,
    input wire logic three_wire_exit,
    input wire logic six_wire_exit,
    input wire logic stop_in,
    input wire logic stop_expected,
    input wire logic fault_in,
    input wire logic bus_voltage_valid_compare,
    output logic [7:0] interface_mode_control,
    output logic stop_weak_pullup,
    output logic data_weak_pulldown,
    output logic fault_complement,
    output logic three_wire_active,
    output logic six_wire_active,
    output logic serial_clock_power
);
    reg_op_type op;
    logic [7:0] next_interface_mode_control;
    logic stop_floating;
    logic protect_on;
    logic serial_mode;
    iface_mode_type mode;

    // the link only reaches this register, so other addresses decode to none
    always_comb begin
        op = REG_NONE;
        if (reg_wr) begin
            case (reg_addr)
                `IFC_ADDR_WRITE: op = REG_WRITE;
                `IFC_ADDR_SET: op = REG_SET;
                `IFC_ADDR_CLEAR: op = REG_CLEAR;
                default: op = REG_NONE;
            endcase
        end
    end

    ifc_reg_update u_update (
        .current(interface_mode_control),
        .op(op),
        .wdata(reg_wdata),
        .three_exit(three_wire_exit),
        .six_exit(six_wire_exit),
        .next_value(next_interface_mode_control)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interface_mode_control <= `IFC_RESET_VALUE;
        end else if (clk_en) begin
            interface_mode_control <= next_interface_mode_control; // [RQ16]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else if (clk_en) begin
            reg_rdata_valid <= 1'b0;
            if (reg_rd && (reg_addr == `IFC_ADDR_WRITE ||
                reg_addr == `IFC_ADDR_SET ||
                reg_addr == `IFC_ADDR_CLEAR)) begin
                reg_rdata <= interface_mode_control; // [RQ2]
                reg_rdata_valid <= 1'b1;
            end
        end
    end

    assign protect_on = !interface_mode_control[`IFC_BIT_PROT_DIS];

    ifc_stop_guard #(
        .HIGH_CYCLES(STOP_HIGH_CYCLES)
    ) u_guard (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .enable(protect_on),
        .stop_in(stop_in),
        .stop_expected(stop_expected),
        .floating(stop_floating)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_weak_pullup <= 1'b1;
            data_weak_pulldown <= 1'b0;
        end else if (clk_en) begin
            stop_weak_pullup <= protect_on; // [RQ3] [RQ5]
            data_weak_pulldown <= protect_on && stop_floating; // [RQ3] [RQ5]
        end
    end

    // the unqualified bit is stored but the comparator is never mixed in:
    // a zero there is unsupported, so no qualified path exists to select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_complement <= 1'b0;
        end else if (clk_en) begin
            fault_complement <= fault_in ^
                interface_mode_control[`IFC_BIT_INVERT]; // [RQ7] [RQ8]
        end
    end

    // several fields at once is undefined; three-wire is given priority
    always_comb begin
        if (interface_mode_control[`IFC_BIT_THREE]) begin
            mode = MODE_THREE; // [RQ11]
        end else if (interface_mode_control[`IFC_BIT_SIX]) begin
            mode = MODE_SIX; // [RQ13]
        end else begin
            mode = MODE_PARALLEL;
        end
    end
    assign serial_mode = (mode != MODE_PARALLEL);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            three_wire_active <= 1'b0;
            six_wire_active <= 1'b0;
            serial_clock_power <= 1'b1;
        end else if (clk_en) begin
            three_wire_active <= (mode == MODE_THREE); // [RQ11]
            six_wire_active <= (mode == MODE_SIX); // [RQ13]
            if (serial_mode && phy_low_power_n) begin
                serial_clock_power <=
                    interface_mode_control[`IFC_BIT_CLK_KEEP]; // [RQ9] [RQ10]
            end else begin
                serial_clock_power <= 1'b1; // [RQ10]
            end
        end
    end

    a_write_plain: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == `IFC_ADDR_WRITE &&
        !three_wire_exit && !six_wire_exit
        |=> interface_mode_control == ($past(reg_wdata) & `IFC_RSVD_MASK))
        else $error("plain write not stored"); // [RQ2]
    a_set_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == `IFC_ADDR_SET
        |=> (interface_mode_control & $past(reg_wdata) & 8'hE8)
            == ($past(reg_wdata) & 8'hE8))
        else $error("set write lost bits"); // [RQ16]
    a_clear_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == `IFC_ADDR_CLEAR
        |=> (interface_mode_control & $past(reg_wdata)) == 8'h00)
        else $error("clear write left bits"); // [RQ16]
    a_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && reg_rd && reg_addr == `IFC_ADDR_CLEAR
        |=> reg_rdata_valid && reg_rdata == $past(interface_mode_control))
        else $error("read data wrong"); // [RQ2]
    a_protect_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && !protect_on |=> !stop_weak_pullup && !data_weak_pulldown)
        else $error("weak resistors kept while disabled"); // [RQ5]
    a_pulldown_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && protect_on && stop_floating |=> data_weak_pulldown)
        else $error("no pull-down on floating stop"); // [RQ3]
    a_float_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && protect_on && stop_in && !stop_expected) [*4]
        |=> stop_floating)
        else $error("floating stop not detected"); // [RQ4]
    a_fault_invert: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en |=> fault_complement ==
            ($past(fault_in) ^ $past(interface_mode_control[`IFC_BIT_INVERT])))
        else $error("fault complement wrong"); // [RQ8]
    a_three_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && three_wire_exit
        |=> !interface_mode_control[`IFC_BIT_THREE])
        else $error("three-wire bit not cleared"); // [RQ12]
    a_six_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && six_wire_exit |=> !interface_mode_control[`IFC_BIT_SIX])
        else $error("six-wire bit not cleared"); // [RQ14]
    a_clock_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && !phy_low_power_n |=> serial_clock_power)
        else $error("clock bit honoured in low power"); // [RQ10]
endmodule
`default_nettype wire

//--- pkg/ifc_defines.svh
// offsets, field positions and reset values of the interface-mode register
`ifndef IFC_DEFINES_SVH
`define IFC_DEFINES_SVH
`define IFC_ADDR_WRITE 6'h07
`define IFC_ADDR_SET 6'h08
`define IFC_ADDR_CLEAR 6'h09
`define IFC_RESET_VALUE 8'h00
`define IFC_RSVD_MASK 8'hEB
`define IFC_BIT_PROT_DIS 7
`define IFC_BIT_UNQUAL 6
`define IFC_BIT_INVERT 5
`define IFC_BIT_CLK_KEEP 3
`define IFC_BIT_THREE 1
`define IFC_BIT_SIX 0
`define IFC_STOP_HIGH_CYCLES 4'h2
`endif

//--- pkg/ifc_pkg.sv
// types of the interface-mode register block
package ifc_pkg;
    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'b00,
        MODE_THREE = 2'b01,
        MODE_SIX = 2'b10
    } iface_mode_type;
    typedef enum logic [1:0] {
        REG_WRITE = 2'b00,
        REG_SET = 2'b01,
        REG_CLEAR = 2'b10,
        REG_NONE = 2'b11
    } reg_op_type;
endpackage

//--- src/ifc_reg_update.sv
// next value of the interface-mode register from a write or a hardware clear
`timescale 1ns/1ps
`default_nettype none
`include "ifc_defines.svh"
module ifc_reg_update
    import ifc_pkg::*;
(
    input wire logic [7:0] current,
    input wire reg_op_type op,
    input wire logic [7:0] wdata,
    input wire logic three_exit,
    input wire logic six_exit,
    output logic [7:0] next_value
);
    logic [7:0] hw_clear;
    always_comb begin
        next_value = current;
        case (op)
            REG_WRITE: next_value = wdata; // [RQ2]
            REG_SET: next_value = current | wdata; // [RQ16]
            REG_CLEAR: next_value = current & ~wdata; // [RQ16]
            default: next_value = current;
        endcase
        hw_clear = 8'h00;
        hw_clear[`IFC_BIT_THREE] = three_exit; // [RQ12]
        hw_clear[`IFC_BIT_SIX] = six_exit; // [RQ14]
        next_value = next_value & ~hw_clear & `IFC_RSVD_MASK;
    end
endmodule
`default_nettype wire

//--- src/ifc_stop_guard.sv
// detects a stop line left floating high while the link should drive it
`timescale 1ns/1ps
`default_nettype none
`include "ifc_defines.svh"
module ifc_stop_guard #(
    parameter logic [3:0] HIGH_CYCLES = `IFC_STOP_HIGH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic stop_in,
    input wire logic stop_expected,
    output logic floating
);
    initial begin
        if (HIGH_CYCLES == 4'h0) begin
            $error("HIGH_CYCLES must be at least one");
        end
    end
    logic [3:0] count;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 4'h0;
            floating <= 1'b0;
        end else if (clk_en) begin
            if (!enable || !stop_in || stop_expected) begin
                count <= 4'h0;
                floating <= 1'b0;
            end else if (count == HIGH_CYCLES) begin
                floating <= 1'b1; // [RQ4]
            end else begin
                count <= count + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/link_model.sv
// link-controller model: register bus requests and the stop line
`timescale 1ns/1ps
`default_nettype none
module link_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic stop_weak_pullup,
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic stop_in,
    output logic stop_expected
);
    logic stop_drive = 1'b1;
    logic stop_level = 1'b0;
    // released line: weak pull-up wins, else it takes the inverse of its last driven level
    assign stop_in = stop_drive ? stop_level : (stop_weak_pullup | ~stop_level);
    assign stop_expected = stop_drive & stop_level;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        v[6] = (a != 6'h09);
        if (a != 6'h09 && v[1]) v[0] = 1'b0;
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d,
                      output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        repeat (3) begin
            #1;
            if (reg_rdata_valid === 1'b1 && !ok) begin
                ok = 1'b1;
                d = reg_rdata;
            end
            @(posedge sys_clk);
        end
    endtask
    task automatic release_stop(input logic r);
        @(posedge sys_clk);
        stop_drive <= ~r;
    endtask
endmodule
`default_nettype wire

//--- verif/ulpi_phy_interface_control_tb.sv
// self-checking bench of the interface-mode control register
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_interface_control_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic phy_low_power_n = 1'b1;
    logic three_wire_exit = 1'b0;
    logic six_wire_exit = 1'b0;
    logic fault_in = 1'b0;
    logic bus_voltage_valid_compare = 1'b0;
    logic reg_wr, reg_rd, reg_rdata_valid, stop_in, stop_expected;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, interface_mode_control;
    logic stop_weak_pullup, data_weak_pulldown, fault_complement;
    logic three_wire_active, six_wire_active, serial_clock_power;
    int error_cnt = 0;
    int checked = 0;
    always #20 sys_clk = ~sys_clk;
    ifc_mode_control #(.STOP_HIGH_CYCLES(4'h2)) uut (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .phy_low_power_n(phy_low_power_n),
        .three_wire_exit(three_wire_exit), .six_wire_exit(six_wire_exit),
        .stop_in(stop_in), .stop_expected(stop_expected), .fault_in(fault_in),
        .bus_voltage_valid_compare(bus_voltage_valid_compare),
        .interface_mode_control(interface_mode_control),
        .stop_weak_pullup(stop_weak_pullup),
        .data_weak_pulldown(data_weak_pulldown),
        .fault_complement(fault_complement),
        .three_wire_active(three_wire_active),
        .six_wire_active(six_wire_active),
        .serial_clock_power(serial_clock_power));
    link_model link (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .stop_weak_pullup(stop_weak_pullup),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .stop_in(stop_in),
        .stop_expected(stop_expected));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic reg_is(input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        for (int a = 7; a <= 9; a++) begin
            link.rd(a[5:0], d, ok);
            chk({7'h00, ok}, 8'h01);
            chk(d, e);
        end
        chk(interface_mode_control, e);
    endtask
    task automatic t_reset;
        reg_is(8'h00);
        chk({7'h00, stop_weak_pullup}, 8'h01);
        chk({7'h00, data_weak_pulldown}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_access;
        logic [7:0] d;
        logic ok;
        link.wr(6'h07, 8'hFE);
        reg_is(8'hEA);
        link.wr(6'h09, 8'hA2);
        reg_is(8'h48);
        link.wr(6'h08, 8'h21);
        reg_is(8'h69);
        link.rd(6'h0A, d, ok);
        chk({7'h00, ok}, 8'h00);
        link.wr(6'h06, 8'h00);
        reg_is(8'h69);
        // a write while the enable is low must leave the register frozen
        @(posedge sys_clk);
        clk_en <= 1'b0;
        link.wr(6'h07, 8'h00);
        tick(1);
        chk(interface_mode_control, 8'h69);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        $display("test access done");
    endtask
    task automatic t_fault;
        for (int i = 0; i < 8; i++) begin
            link.wr(6'h07, {2'b01, i[2], 5'h00});
            @(posedge sys_clk);
            fault_in <= i[0];
            bus_voltage_valid_compare <= i[1];
            tick(2);
            chk({7'h00, fault_complement},
                {7'h00, i[0] ^ i[2]});
        end
        $display("test fault done");
    endtask
    task automatic t_serial;
        for (int m = 0; m < 2; m++) begin
            link.wr(6'h07, m ? 8'h01 : 8'h02);
            tick(2);
            chk({7'h00, m ? six_wire_active : three_wire_active},
                8'h01);
            chk({7'h00, serial_clock_power}, 8'h00);
            link.wr(6'h08, 8'h08);
            tick(2);
            chk({7'h00, serial_clock_power}, 8'h01);
            link.wr(6'h09, 8'h08);
            @(posedge sys_clk);
            phy_low_power_n <= 1'b0;
            tick(2);
            chk({7'h00, serial_clock_power}, 8'h01);
            phy_low_power_n <= 1'b1;
            if (m) six_wire_exit <= 1'b1;
            else three_wire_exit <= 1'b1;
            @(posedge sys_clk);
            six_wire_exit <= 1'b0;
            three_wire_exit <= 1'b0;
            tick(2);
            chk({7'h00, three_wire_active | six_wire_active},
                8'h00);
            chk({7'h00, serial_clock_power}, 8'h01);
            reg_is(8'h40);
        end
        $display("test serial done");
    endtask
    task automatic t_protect;
        int n;
        n = 0;
        link.wr(6'h07, 8'h40);
        link.release_stop(1'b1);
        while (data_weak_pulldown !== 1'b1 && n < 12) begin
            tick(1);
            n++;
        end
        chk({7'h00, data_weak_pulldown}, 8'h01);
        chk({7'h00, n >= 3 && n <= 6}, 8'h01);
        link.wr(6'h08, 8'h80);
        tick(8);
        chk({7'h00, stop_weak_pullup}, 8'h00);
        chk({7'h00, data_weak_pulldown}, 8'h00);
        link.release_stop(1'b0);
        link.wr(6'h09, 8'h80);
        tick(2);
        chk({7'h00, stop_weak_pullup}, 8'h01);
        $display("test protect done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_access;
        t_fault;
        t_serial;
        t_protect;
        summarize;
    end
    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #100000;
        error_cnt++;
        summarize;
    end
endmodule
`default_nettype wire
